/* design/pinov_pkg.sv */
// Constants shared by the port pin override block
package pinov_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [3:0] PINOV_DIR_OFS  = 4'h0;
	localparam logic [3:0] PINOV_OUT_OFS  = 4'h4;
	localparam logic [3:0] PINOV_IN_OFS   = 4'h8;
	localparam logic [3:0] PINOV_CTRL_OFS = 4'hc;
	// ==========================================================
	// Control register fields
	localparam int PINOV_CTRL_PUKILL = 0;
	localparam int PINOV_CTRL_T2AS   = 1;
	localparam int PINOV_CTRL_EXTERNAL_CLOCK_INPUT_SELECT  = 2;
	localparam int PINOV_CTRL_MOSC   = 3;
	localparam int PINOV_CTRL_W      = 4;
	// ==========================================================
	// Reset values
	localparam logic [7:0] PINOV_DIR_RST  = 8'h00;
	localparam logic [7:0] PINOV_OUT_RST  = 8'h00;
	localparam logic [3:0] PINOV_CTRL_RST = 4'h0;
	// ==========================================================
	// Bus responses
	localparam logic [1:0] PINOV_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PINOV_RESP_SLVERR = 2'h2;
	// ==========================================================
	// Pin roles
	localparam int PINOV_PIN_DIVIDED_CLOCK_OUT = 0;
	localparam int PINOV_PIN_T1A  = 1;
	localparam int PINOV_PIN_T1B  = 2;
	localparam int PINOV_PIN_T2A  = 3;
	localparam int PINOV_PIN_MISO = 4;
	localparam int PINOV_PIN_SCK  = 5;
	localparam int PINOV_PIN_OSC  = 7;
	// Direction, output value, pull kill giving a pull-up
	localparam logic [2:0] PINOV_PULLUP_CODE = 3'b010;
	// Cycles after wake in which the unclamped level is looked for
	localparam logic [1:0] PINOV_WAKE_WIN = 2'h3;
endpackage

/* design/pinov_port.sv */
// Eight-pin port with peripheral override logic and AXI4-Lite registers
`timescale 1ns/100ps

module pinov_port
	import pinov_pkg::*;
#(
	parameter int PINS = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              sleep_clamp,
	input  wire logic [PINS-1:0]   ext_int_enable,
	input  wire logic [PINS-1:0]   ext_int_edge_mode,
	input  wire logic [PINS-1:0]   pullup_override_en,
	input  wire logic [PINS-1:0]   pullup_override_val,
	input  wire logic [PINS-1:0]   direction_override_en,
	input  wire logic [PINS-1:0]   direction_override_val,
	input  wire logic [PINS-1:0]   value_override_en,
	input  wire logic [PINS-1:0]   value_override_val,
	input  wire logic [PINS-1:0]   port_toggle_override_en,
	input  wire logic [PINS-1:0]   input_enable_override_en,
	input  wire logic [PINS-1:0]   input_enable_override_val,
	input  wire logic [PINS-1:0]   analog_link_oe,
	input  wire logic [PINS-1:0]   analog_link_drive,
	input  wire logic              timer2_match_a_en,
	input  wire logic              timer2_match_a_out,
	input  wire logic              timer1_match_b_en,
	input  wire logic              timer1_match_b_out,
	input  wire logic              timer1_match_a_en,
	input  wire logic              timer1_match_a_out,
	input  wire logic              divided_clock_en,
	input  wire logic              divided_clock_out,
	input  wire logic [PINS-1:0]   pad_in,
	output logic [PINS-1:0]        pad_out,
	output logic [PINS-1:0]        pad_oe,
	output logic [PINS-1:0]        pad_pullup_en,
	output logic [PINS-1:0]        alt_function_input_tap,
	output logic [PINS-1:0]        analog_pad_link,
	output logic [PINS-1:0]        ext_int_wake_set,
	output logic                   timer1_capture_in,
	output logic                   spi_sck_in,
	output logic                   spi_miso_in
);
	// ==========================================================
	// Storage
	logic [PINS-1:0]        direction_bit_reg;
	logic [PINS-1:0]        output_value_bit_reg;
	logic [PINS-1:0]        in_meta_reg;
	logic [PINS-1:0]        input_sample_bit_reg;
	logic [PINS-1:0]        in_prev_reg;
	logic [PINS-1:0]        input_en_reg;
	logic [PINOV_CTRL_W-1:0] ctrl_reg;
	logic                   sleep_prev_reg;
	logic [1:0]             wake_win_reg;
	logic [3:0]             wr_addr_reg;
	logic [31:0]            wr_data_reg;
	logic [3:0]             wr_strb_reg;
	logic                   aw_held_reg;
	logic                   w_held_reg;

	logic [PINS-1:0] dir_next;
	logic [PINS-1:0] val_next;
	logic [PINS-1:0] pull_next;
	logic [PINS-1:0] die_next;
	logic [PINS-1:0] alt_en;
	logic [PINS-1:0] alt_val;
	logic [PINS-1:0] rd_mask;
	logic            global_pullup_kill;
	logic            pin7_is_clock;
	logic            wr_fire;
	logic            wr_in_toggle;
	logic [31:0]     rd_next;
	logic [1:0]      rd_resp_next;

	assign global_pullup_kill = ctrl_reg[PINOV_CTRL_PUKILL];
	assign pin7_is_clock = (ctrl_reg[PINOV_CTRL_T2AS] & ~ctrl_reg[PINOV_CTRL_EXTERNAL_CLOCK_INPUT_SELECT])
		| ctrl_reg[PINOV_CTRL_MOSC];

	// ==========================================================
	// Alternate function map
	// fixed pin map
	always_comb begin
		alt_en  = '0;
		alt_val = '0;
		alt_en[PINOV_PIN_T2A]   = timer2_match_a_en;
		alt_val[PINOV_PIN_T2A]  = timer2_match_a_out;
		alt_en[PINOV_PIN_T1B]   = timer1_match_b_en;
		alt_val[PINOV_PIN_T1B]  = timer1_match_b_out;
		alt_en[PINOV_PIN_T1A]   = timer1_match_a_en;
		alt_val[PINOV_PIN_T1A]  = timer1_match_a_out;
		alt_en[PINOV_PIN_DIVIDED_CLOCK_OUT]  = divided_clock_en;
		alt_val[PINOV_PIN_DIVIDED_CLOCK_OUT] = divided_clock_out;
	end

	// ==========================================================
	// Per-pin override network
	// per-pin overrides, shared kill
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			logic is_clk;
			logic v_en;
			logic v_val;
			assign is_clk = (gi == PINOV_PIN_OSC) && pin7_is_clock;
			assign v_en   = value_override_en[gi] | alt_en[gi];
			assign v_val  = value_override_en[gi] ? value_override_val[gi] : alt_val[gi];
			assign dir_next[gi] = is_clk ? 1'b0 : analog_link_oe[gi] ? 1'b1 :
				direction_override_en[gi] ? direction_override_val[gi] :
				direction_bit_reg[gi];
			assign val_next[gi] = analog_link_oe[gi] ? analog_link_drive[gi] :
				v_en ? v_val : output_value_bit_reg[gi];
			assign pull_next[gi] = is_clk ? 1'b0 :
				pullup_override_en[gi] ? pullup_override_val[gi] :
				({direction_bit_reg[gi], output_value_bit_reg[gi], global_pullup_kill}
				== PINOV_PULLUP_CODE);
			assign die_next[gi] = is_clk ? 1'b0 :
				input_enable_override_en[gi] ? input_enable_override_val[gi] :
				~(sleep_clamp & ~ext_int_enable[gi]);
			assign rd_mask[gi] = ~is_clk;
		end
	endgenerate

	// ==========================================================
	// Pad drivers
	// reset forces tri-state, no pull
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_oe        <= '0;
			pad_out       <= '0;
			pad_pullup_en <= '0;
			input_en_reg  <= '0;
		end else begin
			pad_oe        <= dir_next;
			pad_out       <= val_next;
			pad_pullup_en <= pull_next;
			input_en_reg  <= die_next;
		end
	end

	// ==========================================================
	// Input path
	// tap ahead of the synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alt_function_input_tap <= '0;
			analog_pad_link        <= '0;
			in_meta_reg            <= '0;
			input_sample_bit_reg   <= '0;
			in_prev_reg            <= '0;
		end else begin
			alt_function_input_tap <= pad_in & input_en_reg;
			analog_pad_link        <= pad_in;
			in_meta_reg            <= pad_in & input_en_reg;
			input_sample_bit_reg   <= in_meta_reg;
			in_prev_reg            <= input_sample_bit_reg;
		end
	end

	// Peripherals synchronise these themselves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer1_capture_in <= 1'b0;
			spi_sck_in        <= 1'b0;
			spi_miso_in       <= 1'b0;
		end else begin
			timer1_capture_in <= pad_in[PINOV_PIN_DIVIDED_CLOCK_OUT] & input_en_reg[PINOV_PIN_DIVIDED_CLOCK_OUT];
			spi_sck_in        <= pad_in[PINOV_PIN_SCK] & input_en_reg[PINOV_PIN_SCK];
			spi_miso_in       <= pad_in[PINOV_PIN_MISO] & input_en_reg[PINOV_PIN_MISO];
		end
	end

	// ==========================================================
	// Wake flag
	// Clamp held the input low, so the first high after wake is an edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_prev_reg   <= 1'b0;
			wake_win_reg     <= '0;
			ext_int_wake_set <= '0;
		end else begin
			sleep_prev_reg <= sleep_clamp;
			if (sleep_prev_reg && !sleep_clamp) begin
				wake_win_reg <= PINOV_WAKE_WIN;
			end else if (wake_win_reg != 2'h0) begin
				wake_win_reg <= wake_win_reg - 2'h1;
			end
			ext_int_wake_set <= {PINS{wake_win_reg != 2'h0}} & input_sample_bit_reg
				& ~in_prev_reg & ext_int_edge_mode & ~ext_int_enable;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_in_toggle = wr_fire && wr_addr_reg == PINOV_IN_OFS && wr_strb_reg[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= PINOV_RESP_OKAY;
			wr_addr_reg   <= '0;
			wr_data_reg   <= '0;
			wr_strb_reg   <= '0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				wr_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg  <= 1'b1;
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_addr_reg[1:0] != 2'h0) ? PINOV_RESP_SLVERR
					: PINOV_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register writes
	// one strobe per register for all pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			direction_bit_reg <= PINOV_DIR_RST;
			ctrl_reg          <= PINOV_CTRL_RST;
		end else if (wr_fire && wr_strb_reg[0]) begin
			if (wr_addr_reg == PINOV_DIR_OFS) begin
				direction_bit_reg <= wr_data_reg[PINS-1:0];
			end
			if (wr_addr_reg == PINOV_CTRL_OFS) begin
				ctrl_reg <= wr_data_reg[PINOV_CTRL_W-1:0];
			end
		end
	end

	// Toggles stack on top of a plain write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_value_bit_reg <= PINOV_OUT_RST;
		end else if (wr_fire && wr_strb_reg[0] && wr_addr_reg == PINOV_OUT_OFS) begin
			output_value_bit_reg <= wr_data_reg[PINS-1:0] ^ port_toggle_override_en;
		end else begin
			output_value_bit_reg <= output_value_bit_reg ^ port_toggle_override_en
				^ (wr_in_toggle ? wr_data_reg[PINS-1:0] : '0);
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	// clock pin reads zero
	always_comb begin
		rd_next      = '0;
		rd_resp_next = PINOV_RESP_OKAY;
		case (s_axi_araddr)
			PINOV_DIR_OFS:  rd_next[PINS-1:0] = direction_bit_reg & rd_mask;
			PINOV_OUT_OFS:  rd_next[PINS-1:0] = output_value_bit_reg & rd_mask;
			PINOV_IN_OFS:   rd_next[PINS-1:0] = input_sample_bit_reg & rd_mask;
			PINOV_CTRL_OFS: rd_next[PINOV_CTRL_W-1:0] = ctrl_reg;
			default:        rd_resp_next = PINOV_RESP_SLVERR;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= PINOV_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_next;
				s_axi_rresp  <= rd_resp_next;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wake;
		$fell(sleep_clamp) ##1 1'b1;
	endsequence

	sequence s_clamp_path;
		!input_en_reg[2] ##2 !input_sample_bit_reg[2];
	endsequence

	chk_reset_tristate: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> pad_oe == '0 && pad_pullup_en == '0)
		else $error("pins not released in reset");
	// Antecedents exclude the reset cycle, whose outputs are reset values
	chk_dir_override: assert property (aresetn && direction_override_en[5]
		&& !analog_link_oe[5] |=> pad_oe[5] == $past(direction_override_val[5]))
		else $error("direction override ignored");
	chk_dir_plain: assert property (aresetn && !direction_override_en[1]
		&& !analog_link_oe[1] |=> pad_oe[1] == $past(direction_bit_reg[1]))
		else $error("driver not following direction bit");
	chk_value_override: assert property (aresetn && value_override_en[4]
		&& !analog_link_oe[4] |=> pad_out[4] == $past(value_override_val[4]))
		else $error("value override ignored");
	chk_pullup_code: assert property (aresetn && !pullup_override_en[5]
		|=> pad_pullup_en[5] == ($past(direction_bit_reg[5]) == 1'b0
		&& $past(output_value_bit_reg[5]) && !$past(global_pullup_kill)))
		else $error("pull-up code wrong");
	chk_pullup_over: assert property (aresetn && pullup_override_en[4]
		|=> pad_pullup_en[4] == $past(pullup_override_val[4]))
		else $error("pull-up override ignored");
	chk_sleep_clamp: assert property (aresetn && sleep_clamp && !ext_int_enable[2]
		&& !input_enable_override_en[2] |=> s_clamp_path)
		else $error("clamp not applied");
	chk_clamp_lift: assert property (aresetn && sleep_clamp && ext_int_enable[1]
		&& !input_enable_override_en[1] |=> input_en_reg[1])
		else $error("clamp not lifted");
	chk_ie_override: assert property (aresetn && input_enable_override_en[3]
		|=> input_en_reg[3] == $past(input_enable_override_val[3]))
		else $error("input enable override ignored");
	chk_toggle_bit: assert property (aresetn && port_toggle_override_en[4] && !wr_fire
		|=> output_value_bit_reg[4] != $past(output_value_bit_reg[4]))
		else $error("toggle override lost");
	chk_pin7_read: assert property (pin7_is_clock && s_axi_arvalid && s_axi_arready
		|=> s_axi_rdata[7] == 1'b0)
		else $error("clock pin read not zero");
	chk_pin7_detach: assert property (aresetn && pin7_is_clock
		|=> !pad_oe[7] && !pad_pullup_en[7])
		else $error("pin 7 still driven");
	chk_wake_only: assert property (ext_int_wake_set[6] |->
		$past(wake_win_reg) != 2'h0 && !$past(ext_int_enable[6]))
		else $error("wake flag outside window");
	chk_wake_seq: assert property (s_wake |-> wake_win_reg == PINOV_WAKE_WIN)
		else $error("wake window not opened");

endmodule

/* tb/pinov_pad_model.sv */
// Far-side pad model: outside drivers, pull-ups and floating pads
`timescale 1ns/100ps
module pinov_pad_model (
	input  wire logic       aclk,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pullup_en,
	input  wire logic [7:0] ext_drive,
	input  wire logic [7:0] ext_level,
	output logic [7:0]      pad_in
);
	logic [7:0] float_reg;
	// Floating pads wander each cycle so no stale level passes for data
	always @(posedge aclk) begin
		float_reg <= (float_reg === 8'h55) ? 8'haa : 8'h55;
	end
	always_comb begin
		pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
			| (~pad_oe & ~ext_drive & (pad_pullup_en | float_reg));
	end
endmodule

/* tb/tb.sv */
// Self-checking bench for the port pin override block
`timescale 1ns/100ps
module tb
	import pinov_pkg::*;
;
	logic        aclk, aresetn, sleep_clamp, wake_clr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        timer1_capture_in, spi_sck_in, spi_miso_in;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, fm_en, fm_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]  ext_int_enable, ext_int_edge_mode, pullup_override_en, pullup_override_val;
	logic [7:0]  direction_override_en, direction_override_val, value_override_en;
	logic [7:0]  value_override_val, port_toggle_override_en, input_enable_override_en;
	logic [7:0]  input_enable_override_val, pad_in, pad_out, pad_oe, pad_pullup_en;
	logic [7:0]  alt_function_input_tap, analog_pad_link, ext_int_wake_set, wake_seen;
	logic [7:0]  ext_drive, ext_level, analog_link_oe, analog_link_drive;
	int          error_cnt, num_checks;

	pinov_port #(.PINS(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_clamp, .ext_int_enable,
		.ext_int_edge_mode, .pullup_override_en, .pullup_override_val, .direction_override_en,
		.direction_override_val, .value_override_en, .value_override_val,
		.port_toggle_override_en, .input_enable_override_en, .input_enable_override_val,
		.analog_link_oe, .analog_link_drive, .divided_clock_en(fm_en[0]),
		.divided_clock_out(fm_out[0]), .timer1_match_a_en(fm_en[1]),
		.timer1_match_a_out(fm_out[1]), .timer1_match_b_en(fm_en[2]),
		.timer1_match_b_out(fm_out[2]), .timer2_match_a_en(fm_en[3]),
		.timer2_match_a_out(fm_out[3]), .pad_in, .pad_out, .pad_oe, .pad_pullup_en,
		.alt_function_input_tap, .analog_pad_link, .ext_int_wake_set, .timer1_capture_in,
		.spi_sck_in, .spi_miso_in);

	pinov_pad_model far (.aclk, .pad_out, .pad_oe, .pad_pullup_en, .ext_drive, .ext_level,
		.pad_in);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Wake pulses last one cycle, so keep a sticky copy
	always @(posedge aclk) begin
		wake_seen <= wake_clr ? 8'h00 : (wake_seen | ext_int_wake_set);
	end
	// ==========================================================
	// Check and bus tasks
	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_pad(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk_reg("read data", exp, rd);
		chk_reg("read resp", {30'h0, PINOV_RESP_OKAY}, {30'h0, rsp});
	endtask
	// Pads settle one cycle after a change; three leaves margin
	task automatic pads(input logic [7:0] oe, input logic [7:0] pu);
		repeat (3) @(posedge aclk);
		chk_pad("pad_oe", oe, pad_oe);
		chk_pad("pad_pullup_en", pu, pad_pullup_en);
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Watchdog, far above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		$display("Error watchdog expired expected done seen hang");
		stop_test();
	end
	// ==========================================================
	// Tests
	initial begin
		logic [3:0] ctl [3] = '{4'h2, 4'h8, 4'h6};
		logic [7:0] msk [3] = '{8'h7f, 8'h7f, 8'hff};
		{aresetn, sleep_clamp, wake_clr, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, fm_en, fm_out} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hf};
		{ext_int_enable, ext_int_edge_mode, port_toggle_override_en} = '0;
		{input_enable_override_en, input_enable_override_val, ext_drive, ext_level} = '0;
		{analog_link_oe, analog_link_drive} = '0;
		{pullup_override_en, pullup_override_val, direction_override_en} = {24'hffffff};
		{direction_override_val, value_override_en, value_override_val} = {24'hffffff};
		pads(8'h00, 8'h00);
		{pullup_override_en, pullup_override_val, direction_override_en} <= '0;
		{direction_override_val, value_override_en, value_override_val} <= '0;
		aresetn <= 1'b1;
		rd_chk(PINOV_DIR_OFS, 32'h0);
		rd_chk(PINOV_OUT_OFS, 32'h0);
		rd_chk(PINOV_CTRL_OFS, 32'h0);
		axi_rd(4'h2);
		chk_reg("unmapped read data", 32'h0, rd);
		chk_reg("unmapped read resp", {30'h0, PINOV_RESP_SLVERR}, {30'h0, rsp});
		axi_wr(4'h1, 32'hff);
		chk_reg("unaligned write", {30'h0, PINOV_RESP_SLVERR}, {30'h0, rsp});
		s_axi_wstrb <= 4'h0;
		axi_wr(PINOV_DIR_OFS, 32'hff);
		s_axi_wstrb <= 4'hf;
		chk_reg("masked write resp", {30'h0, PINOV_RESP_OKAY}, {30'h0, rsp});
		rd_chk(PINOV_DIR_OFS, 32'h0);
		$display("Test reset done");
		axi_wr(PINOV_DIR_OFS, 32'h0f);
		axi_wr(PINOV_OUT_OFS, 32'h35);
		pads(8'h0f, 8'h30);
		chk_pad("pad_out", 8'h05, pad_out & 8'h0f);
		axi_wr(PINOV_CTRL_OFS, 32'h1);
		pads(8'h0f, 8'h00);
		axi_wr(PINOV_CTRL_OFS, 32'h0);
		pullup_override_en <= 8'hff;
		pullup_override_val <= 8'ha5;
		pads(8'h0f, 8'ha5);
		pullup_override_en <= 8'h00;
		direction_override_en <= 8'hf0;
		direction_override_val <= 8'ha0;
		value_override_en <= 8'hff;
		value_override_val <= 8'hc3;
		pads(8'haf, 8'h30);
		chk_pad("pad_out", 8'h83, pad_out & 8'haf);
		{direction_override_en, value_override_en} <= '0;
		axi_wr(PINOV_OUT_OFS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			fm_en <= 4'h1 << i;
			fm_out <= 4'hf;
			pads(8'h0f, 8'h00);
			chk_pad("fixed map", 8'h01 << i, pad_out & 8'h0f);
		end
		fm_en <= 4'h0;
		analog_link_oe <= 8'h40;
		analog_link_drive <= 8'h40;
		pads(8'h4f, 8'h00);
		chk_pad("analog drive", 8'h40, pad_out & 8'h40);
		analog_link_oe <= 8'h00;
		$display("Test override done");
		axi_wr(PINOV_OUT_OFS, 32'h0f);
		port_toggle_override_en <= 8'h11;
		@(posedge aclk);
		port_toggle_override_en <= 8'h00;
		rd_chk(PINOV_OUT_OFS, 32'h1e);
		axi_wr(PINOV_IN_OFS, 32'h03);
		rd_chk(PINOV_OUT_OFS, 32'h1d);
		$display("Test toggle done");
		axi_wr(PINOV_DIR_OFS, 32'h0);
		axi_wr(PINOV_OUT_OFS, 32'h0);
		ext_drive <= 8'hff;
		ext_level <= 8'h5a;
		pads(8'h00, 8'h00);
		chk_pad("input tap", 8'h5a, alt_function_input_tap);
		chk_pad("analog link", 8'h5a, analog_pad_link);
		chk_pad("peripheral taps", 8'h02, {5'h0, spi_sck_in, spi_miso_in, timer1_capture_in});
		rd_chk(PINOV_IN_OFS, 32'h5a);
		sleep_clamp <= 1'b1;
		pads(8'h00, 8'h00);
		chk_pad("clamped tap", 8'h00, alt_function_input_tap);
		ext_int_enable <= 8'h02;
		pads(8'h00, 8'h00);
		chk_pad("interrupt pin tap", 8'h02, alt_function_input_tap);
		input_enable_override_en <= 8'h18;
		input_enable_override_val <= 8'h08;
		pads(8'h00, 8'h00);
		chk_pad("override tap", 8'h0a, alt_function_input_tap);
		{input_enable_override_en, ext_int_enable} <= '0;
		ext_int_edge_mode <= 8'h41;
		wake_clr <= 1'b1;
		@(posedge aclk);
		wake_clr <= 1'b0;
		sleep_clamp <= 1'b0;
		repeat (6) @(posedge aclk);
		chk_pad("wake flag", 8'h40, wake_seen);
		$display("Test sleep done");
		ext_drive <= 8'h00;
		axi_wr(PINOV_DIR_OFS, 32'hff);
		axi_wr(PINOV_OUT_OFS, 32'hff);
		for (int i = 0; i < 3; i++) begin
			axi_wr(PINOV_CTRL_OFS, {28'h0, ctl[i]});
			pads(msk[i], 8'h00);
			rd_chk(PINOV_DIR_OFS, {24'h0, msk[i]});
			rd_chk(PINOV_OUT_OFS, {24'h0, msk[i]});
			rd_chk(PINOV_IN_OFS, {24'h0, msk[i]});
		end
		axi_wr(PINOV_CTRL_OFS, 32'h0);
		axi_wr(PINOV_DIR_OFS, 32'h0f);
		pads(8'h0f, 8'hf0);
		aresetn <= 1'b0;
		pads(8'h00, 8'h00);
		aresetn <= 1'b1;
		rd_chk(PINOV_OUT_OFS, 32'h0);
		$display("Test clock pin and reset done");
		stop_test();
	end
endmodule
